/* File: core/pcf_pkg.sv */
// pcf_pkg: constants and types of the configuration port logic.
// assumes a 50 MHz core clock and 8-bit host data.
package pcf_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_MHZ = 50;
   localparam int POWERUP_BLOCK_US = 500;
   localparam int POWERUP_BLOCK_CYCLES = POWERUP_BLOCK_US * CLK_MHZ;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ***************************************************
   // keys and pointers
   // ***************************************************
   localparam logic [7:0] KEY_ENTER = 8'h55;
   localparam logic [7:0] KEY_EXIT = 8'hAA;
   localparam logic [15:0] DATA_PORT_OFFSET = 16'h0001;
   localparam logic [7:0] PTR_CONFIG_CONTROL = 8'h02;
   localparam logic [7:0] PTR_POINTER_READBACK = 8'h03;
   localparam logic [7:0] PTR_DEVICE_SELECTOR = 8'h07;
   localparam logic [7:0] PTR_CHIP_IDENTITY = 8'h20;
   localparam logic [7:0] PTR_CHIP_REVISION = 8'h21;
   localparam logic [7:0] PTR_POWER_CONTROL = 8'h22;
   localparam logic [7:0] PTR_POWER_MANAGEMENT = 8'h23;
   localparam logic [7:0] PTR_OSCILLATOR_CONTROL = 8'h24;
   localparam logic [7:0] PTR_KEY_PORT_ADDR_LOW = 8'h26;
   localparam logic [7:0] PTR_KEY_PORT_ADDR_HIGH = 8'h27;
   localparam logic [7:0] PTR_CLOCK_MASK = 8'h28;
   localparam logic [7:0] PTR_FACTORY_TEST_ONE = 8'h2D;
   localparam logic [7:0] PTR_FACTORY_TEST_TWO = 8'h2E;
   localparam logic [7:0] PTR_FACTORY_TEST_THREE = 8'h2F;
   localparam logic [7:0] PTR_DEVICE_FIRST = 8'h30;
   localparam logic [7:0] PTR_FLOPPY_ACTIVATE = 8'h30;
   localparam logic [7:0] PTR_FLOPPY_BASE_HIGH = 8'h60;
   localparam logic [7:0] PTR_FLOPPY_BASE_LOW = 8'h61;
   localparam logic [7:0] PTR_FLOPPY_IRQ_SELECT = 8'h70;
   localparam logic [7:0] PTR_FLOPPY_DMA_SELECT = 8'h74;
   localparam logic [7:0] PTR_FLOPPY_MODE = 8'hF0;
   localparam logic [7:0] PTR_FLOPPY_OPTION = 8'hF1;
   localparam logic [7:0] PTR_FLOPPY_DRIVE_TYPE = 8'hF2;
   localparam logic [7:0] PTR_FLOPPY_DRIVE_ZERO = 8'hF4;
   localparam logic [7:0] PTR_FLOPPY_DRIVE_ONE = 8'hF5;
   localparam logic [7:0] FLOPPY_DEVICE = 8'h00;
   localparam int SOFT_RESET_BIT = 0;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_POINTER_READBACK = 8'h03;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OSCILLATOR_CONTROL = 8'h04;
   localparam logic [7:0] RST_KEY_LOW_STRAP0 = 8'hF0;
   localparam logic [7:0] RST_KEY_LOW_STRAP1 = 8'h70;
   localparam logic [7:0] RST_KEY_HIGH = 8'h03;
   localparam logic [7:0] RST_FLOPPY_BASE_HIGH = 8'h03;
   localparam logic [7:0] RST_FLOPPY_BASE_LOW = 8'hF0;
   localparam logic [7:0] RST_FLOPPY_IRQ_SELECT = 8'h06;
   localparam logic [7:0] RST_FLOPPY_DMA_SELECT = 8'h02;
   localparam logic [7:0] RST_FLOPPY_MODE = 8'h0E;
   localparam logic [7:0] RST_FLOPPY_DRIVE_TYPE = 8'hFF;

   // two states only
   typedef enum logic {PCF_RUN, PCF_CONFIG} pcf_state_t;

endpackage : pcf_pkg

/* File: core/pcf_ctl_if.sv */
// pcf_ctl_if: reset, strap and power-up blocking signals.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
interface pcf_ctl_if;
   logic hard_reset;
   logic strap_load;
   logic strap_value;
   logic host_blocked;
   modport guard (output hard_reset, output strap_load, output strap_value,
      output host_blocked);
   modport core (input hard_reset, input strap_load, input strap_value,
      input host_blocked);
endinterface : pcf_ctl_if

/* File: core/pcf_reset_guard.sv */
// pcf_reset_guard: synchronises the hard reset and strap pins, catches
// the strap, and blocks host access after power-on.
// assumes rst is the main-supply power-on reset.
`timescale 1ns/100ps
module pcf_reset_guard #(
   parameter int POWERUP_CYCLES = pcf_pkg::POWERUP_BLOCK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic host_hard_reset_in,
   input wire logic strap_pin,
   // to the core
   pcf_ctl_if.guard ctl
);
   logic [1:0] hard_sync;
   logic [1:0] strap_sync;
   logic [1:0] settle;
   logic [15:0] block_cnt;

   // two-flop synchronisers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hard_sync <= 2'h0;
         strap_sync <= 2'h0;
      end else begin
         hard_sync <= {hard_sync[0], host_hard_reset_in};
         strap_sync <= {strap_sync[0], strap_pin};
      end
   end

   // hard reset level and strap catch on power-on release or reset fall
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl.hard_reset <= 1'b0;
         ctl.strap_load <= 1'b0;
         ctl.strap_value <= 1'b0;
         settle <= 2'h0;
      end else begin
         ctl.hard_reset <= hard_sync[1];
         if (settle != pcf_pkg::STRAP_SETTLE) begin
            settle <= settle + 2'h1;
         end
         ctl.strap_load <= (settle == pcf_pkg::STRAP_SETTLE - 2'h1) ||
            (ctl.hard_reset && !hard_sync[1]);
         ctl.strap_value <= strap_sync[1];
      end
   end

   // host accesses held off after power-on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         block_cnt <= 16'(POWERUP_CYCLES);
         ctl.host_blocked <= 1'b1;
      end else begin
         if (block_cnt != 16'h0000) begin
            block_cnt <= block_cnt - 16'h0001;
         end
         ctl.host_blocked <= (block_cnt > 16'h0001);
      end
   end

endmodule : pcf_reset_guard

/* File: core/pcf_config_port.sv */
// pcf_config_port: key, index and data port logic with the global and
// floppy function configuration registers.
// assumes host bus strobes are synchronous one-cycle pulses on clk.
//
// Operation
// - a single write of 0x55 to the key port enters configuration
// - index and data ports respond only in configuration state
// - writing 0xAA to the key port while configuring returns to run
// - only run and configuration states; run accepts the entry key unless aen, the power-up block or hard reset is active
// - index port sits at the key address, data port at key address plus one
// - pointer 0x07 then data write latches the logical device selector
// - pointer write then data access reaches that register of the device
// - global registers reachable whatever the selector holds
// - bit 0 written to pointer 0x02 soft-resets registers that have soft defaults
// - power-on or host hard reset loads every hard default
// - all host accesses ignored for 500 us after power-on
// - identity and revision at 0x20 and 0x21 are fixed read-only codes
// - key address resets to strap-chosen low byte and 0x03; soft reset keeps it
// - floppy activate 0x00, base 0x03 high 0xF0 low, on hard and soft reset
// - strap caught at hard reset fall or power-on release
// - after hard reset the device is in run state with devices disabled
`timescale 1ns/100ps
module pcf_config_port #(
   parameter int POWERUP_CYCLES = pcf_pkg::POWERUP_BLOCK_CYCLES,
   parameter logic [7:0] CHIP_IDENTITY = 8'h5A, // arbitrary value
   parameter logic [7:0] CHIP_REVISION = 8'hA7 // arbitrary value
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic host_hard_reset_in,
   input wire logic strap_pin,
   // host i/o bus
   input wire logic [15:0] io_addr,
   input wire logic io_aen,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   // status
   output logic config_active,
   output logic host_blocked,
   // floppy function configuration
   output logic floppy_enable,
   output logic [7:0] floppy_base_high,
   output logic [7:0] floppy_base_low,
   output logic [7:0] floppy_irq_select,
   output logic [7:0] floppy_dma_select
);

   // ********************
   // declarations
   // ********************
   pcf_ctl_if ctl ();
   pcf_pkg::pcf_state_t state;
   logic [7:0] pointer, device_selector, pointer_readback, power_control, power_management;
   logic [7:0] oscillator_control, key_port_addr_low, key_port_addr_high, clock_mask;
   logic [7:0] factory_test_one, factory_test_two, factory_test_three, floppy_activate;
   logic [7:0] floppy_mode, floppy_option, floppy_drive_type, floppy_drive_zero;
   logic [7:0] floppy_drive_one, next_rdata;
   logic [15:0] key_addr;
   logic bus_ok, key_hit, data_hit, configuring, key_wr, ptr_wr, data_wr, data_rd;
   logic ptr_rd, soft_reset, floppy_sel;

   // address compare used by both port decoders
   function automatic logic port_hit(input logic [15:0] addr,
      input logic [15:0] base, input logic [15:0] offset);
      port_hit = (addr == 16'(base + offset));
   endfunction : port_hit

   // reset, strap and power-up guard
   pcf_reset_guard #(
      .POWERUP_CYCLES(POWERUP_CYCLES)
   ) u_guard (
      .clk(clk),
      .rst(rst),
      .host_hard_reset_in(host_hard_reset_in),
      .strap_pin(strap_pin),
      .ctl(ctl.guard)
   );

   // ********************
   // port decode
   // ********************

   // accesses qualified by aen and the power-up block
   assign key_addr = {key_port_addr_high, key_port_addr_low};
   assign bus_ok = !io_aen && !ctl.host_blocked;
   assign key_hit = port_hit(io_addr, key_addr, 16'h0000);
   assign data_hit = port_hit(io_addr, key_addr, pcf_pkg::DATA_PORT_OFFSET);
   assign configuring = (state == pcf_pkg::PCF_CONFIG);
   assign key_wr = io_wr && bus_ok && key_hit;
   assign ptr_wr = key_wr && configuring && (io_wdata != pcf_pkg::KEY_EXIT);
   assign data_wr = io_wr && bus_ok && data_hit && configuring;
   assign data_rd = io_rd && bus_ok && data_hit && configuring;
   assign ptr_rd = io_rd && bus_ok && key_hit && configuring;
   assign soft_reset = data_wr && (pointer == pcf_pkg::PTR_CONFIG_CONTROL) &&
      io_wdata[pcf_pkg::SOFT_RESET_BIT];
   assign floppy_sel = (device_selector == pcf_pkg::FLOPPY_DEVICE) &&
      (pointer >= pcf_pkg::PTR_DEVICE_FIRST);

   // ********************
   // state machine
   // ********************

   // run and configuration, switched by key port writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= pcf_pkg::PCF_RUN;
      end else if (ctl.hard_reset) begin
         state <= pcf_pkg::PCF_RUN;
      end else begin
         unique case (state)
            pcf_pkg::PCF_RUN: begin
               if (key_wr && io_wdata == pcf_pkg::KEY_ENTER) begin
                  state <= pcf_pkg::PCF_CONFIG;
               end
            end
            pcf_pkg::PCF_CONFIG: begin
               if (key_wr && io_wdata == pcf_pkg::KEY_EXIT) begin
                  state <= pcf_pkg::PCF_RUN;
               end
            end
         endcase
      end
   end

   // index pointer written through the index port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pointer <= pcf_pkg::RST_POINTER;
      end else if (ctl.hard_reset) begin
         pointer <= pcf_pkg::RST_POINTER;
      end else if (ptr_wr) begin
         pointer <= io_wdata;
      end
   end

   // ********************
   // global registers
   // ********************

   // logical device selector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         device_selector <= pcf_pkg::RST_ZERO;
      end else if (ctl.hard_reset || soft_reset) begin
         device_selector <= pcf_pkg::RST_ZERO;
      end else if (data_wr && pointer == pcf_pkg::PTR_DEVICE_SELECTOR) begin
         device_selector <= io_wdata;
      end
   end

   // key port address, strap chosen, untouched by soft reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_port_addr_low <= pcf_pkg::RST_KEY_LOW_STRAP0;
         key_port_addr_high <= pcf_pkg::RST_KEY_HIGH;
      end else if (ctl.strap_load) begin
         key_port_addr_low <= ctl.strap_value ? pcf_pkg::RST_KEY_LOW_STRAP1 :
            pcf_pkg::RST_KEY_LOW_STRAP0;
         key_port_addr_high <= pcf_pkg::RST_KEY_HIGH;
      end else if (ctl.hard_reset) begin
         key_port_addr_high <= pcf_pkg::RST_KEY_HIGH;
      end else if (data_wr) begin
         if (pointer == pcf_pkg::PTR_KEY_PORT_ADDR_LOW) begin
            key_port_addr_low <= io_wdata;
         end
         if (pointer == pcf_pkg::PTR_KEY_PORT_ADDR_HIGH) begin
            key_port_addr_high <= io_wdata;
         end
      end
   end

   // registers with a soft default
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_control <= pcf_pkg::RST_ZERO;
         clock_mask <= pcf_pkg::RST_ZERO;
      end else if (ctl.hard_reset || soft_reset) begin
         power_control <= pcf_pkg::RST_ZERO;
         clock_mask <= pcf_pkg::RST_ZERO;
      end else if (data_wr) begin
         if (pointer == pcf_pkg::PTR_POWER_CONTROL) begin
            power_control <= io_wdata;
         end
         if (pointer == pcf_pkg::PTR_CLOCK_MASK) begin
            clock_mask <= io_wdata;
         end
      end
   end

   // registers that soft reset leaves alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pointer_readback <= pcf_pkg::RST_POINTER_READBACK;
         power_management <= pcf_pkg::RST_ZERO;
         oscillator_control <= pcf_pkg::RST_OSCILLATOR_CONTROL;
         factory_test_one <= pcf_pkg::RST_ZERO;
         factory_test_two <= pcf_pkg::RST_ZERO;
         factory_test_three <= pcf_pkg::RST_ZERO;
      end else if (ctl.hard_reset) begin
         pointer_readback <= pcf_pkg::RST_POINTER_READBACK;
         power_management <= pcf_pkg::RST_ZERO;
         oscillator_control <= pcf_pkg::RST_OSCILLATOR_CONTROL;
         factory_test_one <= pcf_pkg::RST_ZERO;
         factory_test_two <= pcf_pkg::RST_ZERO;
         factory_test_three <= pcf_pkg::RST_ZERO;
      end else if (data_wr) begin
         unique case (pointer)
            pcf_pkg::PTR_POINTER_READBACK: pointer_readback <= io_wdata;
            pcf_pkg::PTR_POWER_MANAGEMENT: power_management <= io_wdata;
            pcf_pkg::PTR_OSCILLATOR_CONTROL: oscillator_control <= io_wdata;
            pcf_pkg::PTR_FACTORY_TEST_ONE: factory_test_one <= io_wdata;
            pcf_pkg::PTR_FACTORY_TEST_TWO: factory_test_two <= io_wdata;
            pcf_pkg::PTR_FACTORY_TEST_THREE: factory_test_three <= io_wdata;
            default: ;
         endcase
      end
   end

   // ********************
   // floppy function registers
   // ********************

   // registers restored by both hard and soft reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         floppy_activate <= pcf_pkg::RST_ZERO;
         floppy_base_high <= pcf_pkg::RST_FLOPPY_BASE_HIGH;
         floppy_base_low <= pcf_pkg::RST_FLOPPY_BASE_LOW;
         floppy_irq_select <= pcf_pkg::RST_FLOPPY_IRQ_SELECT;
         floppy_dma_select <= pcf_pkg::RST_FLOPPY_DMA_SELECT;
      end else if (ctl.hard_reset || soft_reset) begin
         floppy_activate <= pcf_pkg::RST_ZERO;
         floppy_base_high <= pcf_pkg::RST_FLOPPY_BASE_HIGH;
         floppy_base_low <= pcf_pkg::RST_FLOPPY_BASE_LOW;
         floppy_irq_select <= pcf_pkg::RST_FLOPPY_IRQ_SELECT;
         floppy_dma_select <= pcf_pkg::RST_FLOPPY_DMA_SELECT;
      end else if (data_wr && floppy_sel) begin
         unique case (pointer)
            pcf_pkg::PTR_FLOPPY_ACTIVATE: floppy_activate <= io_wdata;
            pcf_pkg::PTR_FLOPPY_BASE_HIGH: floppy_base_high <= io_wdata;
            pcf_pkg::PTR_FLOPPY_BASE_LOW: floppy_base_low <= io_wdata;
            pcf_pkg::PTR_FLOPPY_IRQ_SELECT: floppy_irq_select <= io_wdata;
            pcf_pkg::PTR_FLOPPY_DMA_SELECT: floppy_dma_select <= io_wdata;
            default: ;
         endcase
      end
   end

   // mode registers, hard reset only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         floppy_mode <= pcf_pkg::RST_FLOPPY_MODE;
         floppy_option <= pcf_pkg::RST_ZERO;
         floppy_drive_type <= pcf_pkg::RST_FLOPPY_DRIVE_TYPE;
         floppy_drive_zero <= pcf_pkg::RST_ZERO;
         floppy_drive_one <= pcf_pkg::RST_ZERO;
      end else if (ctl.hard_reset) begin
         floppy_mode <= pcf_pkg::RST_FLOPPY_MODE;
         floppy_option <= pcf_pkg::RST_ZERO;
         floppy_drive_type <= pcf_pkg::RST_FLOPPY_DRIVE_TYPE;
         floppy_drive_zero <= pcf_pkg::RST_ZERO;
         floppy_drive_one <= pcf_pkg::RST_ZERO;
      end else if (data_wr && floppy_sel) begin
         unique case (pointer)
            pcf_pkg::PTR_FLOPPY_MODE: floppy_mode <= io_wdata;
            pcf_pkg::PTR_FLOPPY_OPTION: floppy_option <= io_wdata;
            pcf_pkg::PTR_FLOPPY_DRIVE_TYPE: floppy_drive_type <= io_wdata;
            pcf_pkg::PTR_FLOPPY_DRIVE_ZERO: floppy_drive_zero <= io_wdata;
            pcf_pkg::PTR_FLOPPY_DRIVE_ONE: floppy_drive_one <= io_wdata;
            default: ;
         endcase
      end
   end

   // ********************
   // read path
   // ********************

   // data port read mux; unmapped and write-only read as zero
   always_comb begin
      next_rdata = 8'h00;
      if (pointer < pcf_pkg::PTR_DEVICE_FIRST) begin
         unique case (pointer)
            pcf_pkg::PTR_POINTER_READBACK: next_rdata = pointer_readback;
            pcf_pkg::PTR_DEVICE_SELECTOR: next_rdata = device_selector;
            pcf_pkg::PTR_CHIP_IDENTITY: next_rdata = CHIP_IDENTITY;
            pcf_pkg::PTR_CHIP_REVISION: next_rdata = CHIP_REVISION;
            pcf_pkg::PTR_POWER_CONTROL: next_rdata = power_control;
            pcf_pkg::PTR_POWER_MANAGEMENT: next_rdata = power_management;
            pcf_pkg::PTR_OSCILLATOR_CONTROL: next_rdata = oscillator_control;
            pcf_pkg::PTR_KEY_PORT_ADDR_LOW: next_rdata = key_port_addr_low;
            pcf_pkg::PTR_KEY_PORT_ADDR_HIGH: next_rdata = key_port_addr_high;
            pcf_pkg::PTR_CLOCK_MASK: next_rdata = clock_mask;
            pcf_pkg::PTR_FACTORY_TEST_ONE: next_rdata = factory_test_one;
            pcf_pkg::PTR_FACTORY_TEST_TWO: next_rdata = factory_test_two;
            pcf_pkg::PTR_FACTORY_TEST_THREE: next_rdata = factory_test_three;
            default: next_rdata = 8'h00;
         endcase
      end else if (floppy_sel) begin
         unique case (pointer)
            pcf_pkg::PTR_FLOPPY_ACTIVATE: next_rdata = floppy_activate;
            pcf_pkg::PTR_FLOPPY_BASE_HIGH: next_rdata = floppy_base_high;
            pcf_pkg::PTR_FLOPPY_BASE_LOW: next_rdata = floppy_base_low;
            pcf_pkg::PTR_FLOPPY_IRQ_SELECT: next_rdata = floppy_irq_select;
            pcf_pkg::PTR_FLOPPY_DMA_SELECT: next_rdata = floppy_dma_select;
            pcf_pkg::PTR_FLOPPY_MODE: next_rdata = floppy_mode;
            pcf_pkg::PTR_FLOPPY_OPTION: next_rdata = floppy_option;
            pcf_pkg::PTR_FLOPPY_DRIVE_TYPE: next_rdata = floppy_drive_type;
            pcf_pkg::PTR_FLOPPY_DRIVE_ZERO: next_rdata = floppy_drive_zero;
            pcf_pkg::PTR_FLOPPY_DRIVE_ONE: next_rdata = floppy_drive_one;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // read data registered, driven for one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         io_rdata <= 8'h00;
         io_rdata_oe <= 1'b0;
      end else begin
         io_rdata_oe <= data_rd || ptr_rd;
         io_rdata <= data_rd ? next_rdata : (ptr_rd ? pointer : 8'h00);
      end
   end

   // ********************
   // status outputs
   // ********************

   // registered copies of state and blocking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         config_active <= 1'b0;
         host_blocked <= 1'b1;
         floppy_enable <= 1'b0;
      end else begin
         config_active <= configuring && !ctl.hard_reset;
         host_blocked <= ctl.host_blocked;
         floppy_enable <= floppy_activate[0] && !soft_reset && !ctl.hard_reset;
      end
   end

endmodule : pcf_config_port

/* File: verif/pcf_sva.sv */
// pcf_sva: port checks of pcf_config_port.
// assumes one clock domain and rst active high.
`timescale 1ns/100ps
module pcf_sva #(parameter int POWERUP_CYCLES = 20) (
   // clock, resets
   input wire logic clk, rst, host_hard_reset_in,
   // host bus
   input wire logic [15:0] io_addr,
   input wire logic io_aen, io_wr, io_rd,
   input wire logic [7:0] io_wdata, io_rdata,
   // status and floppy outputs
   input wire logic io_rdata_oe, config_active, host_blocked, floppy_enable,
   input wire logic [7:0] floppy_base_high, floppy_base_low,
   input wire logic [7:0] floppy_irq_select, floppy_dma_select
);
   int cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // cycles since power-on release, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt <= 0;
      else if (cnt < 9999) cnt <= cnt + 1;
   end
   property p_oe; io_rdata_oe |-> $past(io_rd && !io_aen); endproperty
   a_oe: assert property (p_oe) else $error("read data without read");
   property p_idle; !io_rdata_oe |-> io_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero");
   property p_run_rd; !config_active && !$past(io_wr) && io_rd |=> !io_rdata_oe; endproperty
   a_run_rd: assert property (p_run_rd) else $error("read answered in run");
   property p_enter; !config_active && !host_blocked && !$past(io_wr) && io_wr && !io_aen
      && io_addr == 16'h03F0 && io_wdata == 8'h55 |=> ##1 config_active; endproperty
   a_enter: assert property (p_enter) else $error("entry key missed");
   property p_exit; config_active && !$past(io_wr) && io_wr && !io_aen
      && io_addr == 16'h03F0 && io_wdata == 8'hAA |=> ##1 !config_active; endproperty
   a_exit: assert property (p_exit) else $error("exit key missed");
   property p_stay; !config_active && !$past(io_wr) && io_wr && io_wdata != 8'h55
      |=> ##1 !config_active; endproperty
   a_stay: assert property (p_stay) else $error("left run without key");
   property p_block; cnt < POWERUP_CYCLES - 1 ? host_blocked
      : (cnt > POWERUP_CYCLES + 2 ? !host_blocked : 1'b1); endproperty
   a_block: assert property (p_block) else $error("power-up block length");
   property p_hard; $fell(host_hard_reset_in) |-> ##4 !floppy_enable
      && floppy_base_high == 8'h03 && floppy_base_low == 8'hF0
      && floppy_irq_select == 8'h06 && floppy_dma_select == 8'h02; endproperty
   a_hard: assert property (p_hard) else $error("hard defaults missing");
endmodule : pcf_sva
bind pcf_config_port pcf_sva #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_pcf_sva (.*);

/* File: verif/pcf_host_model.sv */
// pcf_host_model: host processor on the i/o bus.
// assumes calls from the bench; drives just after the falling edge.
`timescale 1ns/100ps
module pcf_host_model (
   // clock
   input wire logic clk,
   // host bus
   output logic [15:0] io_addr,
   output logic io_aen, io_wr, io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe
);
   initial {io_addr, io_aen, io_wr, io_rd, io_wdata} = '0;
   // one write; a released bus shows the inverse
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e);
      @(negedge clk);
      {io_addr, io_wdata, io_aen, io_wr} = {a, d, e, 1'b1};
      @(negedge clk);
      {io_addr, io_wdata, io_aen, io_wr} = {~a, ~d, 2'b00};
   endtask : wr
   // one read, data taken while the answer stands
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      {io_addr, io_rd} = {a, 1'b1};
      @(negedge clk);
      {io_addr, io_rd} = {~a, 1'b0};
      d = io_rdata_oe ? io_rdata : 8'hXX;
   endtask : rd
endmodule : pcf_host_model

/* File: verif/pcf_tb.sv */
// pcf tb: drives the configuration port through the host model.
// assumes the package, design and checker are compiled first.
`timescale 1ns/100ps
module pnp_config_port_state_machine_tb_top;
   localparam logic [7:0] ID = 8'h5A; // arbitrary value
   localparam logic [7:0] REV = 8'hA7; // arbitrary value
   logic clk = 1'b0, rst = 1'b1, pin_rst = 1'b0, strap = 1'b0, io_aen, io_wr, io_rd;
   logic io_rdata_oe, cfg_on, blk, en;
   logic [15:0] io_addr, key = 16'h03F0;
   logic [7:0] io_wdata, io_rdata, bh, bl, irq, dma, d, e[256];
   logic [7:0] ptrs[21] = '{8'h02, 8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26,
      8'h27, 8'h28, 8'h2F, 8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2, 8'hF4};
   int n_mismatch = 0, checked = 0, seed = 32'h160E, cyc = 0;
   pcf_config_port #(.POWERUP_CYCLES(20), .CHIP_IDENTITY(ID), .CHIP_REVISION(REV))
      i_pcf_config_port (.clk, .rst, .host_hard_reset_in(pin_rst), .strap_pin(strap),
      .io_addr, .io_aen, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_oe,
      .config_active(cfg_on), .host_blocked(blk), .floppy_enable(en), .floppy_base_high(bh),
      .floppy_base_low(bl), .floppy_irq_select(irq), .floppy_dma_select(dma));
   pcf_host_model i_pcf_host_model (.clk, .io_addr, .io_aen, .io_wr, .io_rd, .io_wdata,
      .io_rdata, .io_rdata_oe);
   // clock and hang guard
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (++cyc == 5000) begin
      n_mismatch++;
      finish_test();
   end
   function automatic logic [7:0] hard_val(input logic [7:0] p);
      case (p)
         8'h03, 8'h27, 8'h60: return 8'h03;
         8'h20: return ID;
         8'h21: return REV;
         8'h24: return 8'h04;
         8'h26: return strap ? 8'h70 : 8'hF0;
         8'h61: return 8'hF0;
         8'h70: return 8'h06;
         8'h74: return 8'h02;
         8'hF0: return 8'h0E;
         8'hF2: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction : hard_val
   task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
      checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", s, x, g);
      end
   endtask : chk
   task automatic cfg(input logic [7:0] p, input logic [7:0] v);
      i_pcf_host_model.wr(key, p, 1'b0);
      i_pcf_host_model.wr(key + 16'h0001, v, 1'b0);
   endtask : cfg
   task automatic get(input logic [7:0] p);
      i_pcf_host_model.wr(key, p, 1'b0);
      i_pcf_host_model.rd(key + 16'h0001, d);
   endtask : get
   task automatic step(input logic [7:0] v, input logic x);
      i_pcf_host_model.wr(key, v, 1'b0);
      repeat (2) @(negedge clk);
      chk("config_active", {7'h00, x}, {7'h00, cfg_on});
   endtask : step
   task automatic sweep(input string s);
      foreach (ptrs[i]) begin
         get(ptrs[i]);
         chk($sformatf("reg_%h", ptrs[i]), e[ptrs[i]], d);
      end
      $display("test %s done", s);
   endtask : sweep
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   initial begin
      foreach (e[i]) e[i] = hard_val(i[7:0]);
      repeat (16) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      step(8'h55, 1'b0);
      for (int k = 0; k < 40 && blk !== 1'b0; k++) @(negedge clk);
      i_pcf_host_model.wr(key, 8'h55, 1'b1);
      step(8'h12, 1'b0);
      step(8'h55, 1'b1);
      sweep("defaults");
      foreach (ptrs[i]) if (!(ptrs[i] inside {8'h02, 8'h03, 8'h07, 8'h26, 8'h27})) begin
         d = 8'($random(seed));
         cfg(ptrs[i], d);
         if (!(ptrs[i] inside {8'h20, 8'h21})) e[ptrs[i]] = d;
      end
      chk("base_low_pin", e[8'h61], bl);
      chk("enable_pin", {7'h00, e[8'h30][0]}, {7'h00, en});
      sweep("random");
      d = 8'($random(seed)) | 8'h01;
      cfg(8'h07, d);
      e[8'h07] = d;
      get(8'h22);
      chk("global_reach", e[8'h22], d);
      i_pcf_host_model.rd(key, d);
      chk("ptr_read", 8'h22, d);
      get(8'h30);
      chk("other_device", 8'h00, d);
      cfg(8'h02, 8'h01);
      foreach (e[i]) if (i inside {8'h07, 8'h22, 8'h28, 8'h30, 8'h60, 8'h61, 8'h70, 8'h74})
         e[i] = hard_val(i[7:0]);
      sweep("soft");
      step(8'hAA, 1'b0);
      cfg(8'h61, 8'h5A);
      chk("run_write", e[8'h61], bl);
      i_pcf_host_model.rd(key + 16'h0001, d);
      chk("run_read", 8'hXX, d);
      step(8'h55, 1'b1);
      cfg(8'h30, 8'h01);
      cfg(8'h60, 8'h5A);
      {strap, pin_rst} = 2'b11;
      repeat (5) @(negedge clk);
      pin_rst = 1'b0;
      repeat (6) @(negedge clk);
      chk("after_hard", 8'h00, {7'h00, cfg_on});
      key = 16'h0370;
      foreach (e[i]) e[i] = hard_val(i[7:0]);
      step(8'h55, 1'b1);
      sweep("hard");
      finish_test();
   end
endmodule : pnp_config_port_state_machine_tb_top
